// ==== trace_register_scan_access.v ====
// test port access to the trace macrocell registers
// assumes tck, tms, tdi, trstN come from pins; register port is on mclk
`include "trace_scan_regs.vh"
`default_nettype none

module trace_register_scan_access (
	input wire mclk,
	input wire rst_n,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trstN,
	output reg tdo,
	output reg tdoOe,
	output reg [`TRC_ADDR_W-1:0] regAddr,
	output reg [`TRC_DATA_W-1:0] regWrData,
	output reg regWrite,
	output reg regRead,
	input wire [`TRC_DATA_W-1:0] regRdData,
	output wire traceChainActive
);

	// tap controller states, one-hot
	localparam [15:0] S_TLR = 16'h0001;
	localparam [15:0] S_RTI = 16'h0002;
	localparam [15:0] S_SELDR = 16'h0004;
	localparam [15:0] S_CAPDR = 16'h0008;
	localparam [15:0] S_SHDR = 16'h0010;
	localparam [15:0] S_EX1DR = 16'h0020;
	localparam [15:0] S_PADR = 16'h0040;
	localparam [15:0] S_EX2DR = 16'h0080;
	localparam [15:0] S_UPDR = 16'h0100;
	localparam [15:0] S_SELIR = 16'h0200;
	localparam [15:0] S_CAPIR = 16'h0400;
	localparam [15:0] S_SHIR = 16'h0800;
	localparam [15:0] S_EX1IR = 16'h1000;
	localparam [15:0] S_PAIR = 16'h2000;
	localparam [15:0] S_EX2IR = 16'h4000;
	localparam [15:0] S_UPIR = 16'h8000;

	wire [`TRC_SYNC_W-1:0] pinsRaw;
	wire [`TRC_SYNC_W-1:0] pins;
	reg tckPrev;
	wire tckRise;
	wire tckFall;
	wire tmsIn;
	wire tdiIn;
	wire tapReset;
	reg [15:0] tapState;
	wire [15:0] next_tapState;
	reg [`TRC_IR_W-1:0] irShift;
	reg [`TRC_IR_W-1:0] ir;
	reg [`TRC_SEL_W-1:0] selShift;
	reg [`TRC_SEL_W-1:0] chainSel;
	reg [`TRC_CHAIN_W-1:0] chain;
	reg bypassBit;
	reg [`TRC_DATA_W-1:0] readHold;
	reg readPending;
	reg tdoBit;

	// next tap state from current state and tms
	function [15:0] tapNext;
		input [15:0] s;
		input m;
		begin
			case (s)
				S_TLR: tapNext = m ? S_TLR : S_RTI;
				S_RTI: tapNext = m ? S_SELDR : S_RTI;
				S_SELDR: tapNext = m ? S_SELIR : S_CAPDR;
				S_CAPDR: tapNext = m ? S_EX1DR : S_SHDR;
				S_SHDR: tapNext = m ? S_EX1DR : S_SHDR;
				S_EX1DR: tapNext = m ? S_UPDR : S_PADR;
				S_PADR: tapNext = m ? S_EX2DR : S_PADR;
				S_EX2DR: tapNext = m ? S_UPDR : S_SHDR;
				S_UPDR: tapNext = m ? S_SELDR : S_RTI;
				S_SELIR: tapNext = m ? S_TLR : S_CAPIR;
				S_CAPIR: tapNext = m ? S_EX1IR : S_SHIR;
				S_SHIR: tapNext = m ? S_EX1IR : S_SHIR;
				S_EX1IR: tapNext = m ? S_UPIR : S_PAIR;
				S_PAIR: tapNext = m ? S_EX2IR : S_PAIR;
				S_EX2IR: tapNext = m ? S_UPIR : S_SHIR;
				S_UPIR: tapNext = m ? S_SELDR : S_RTI;
				default: tapNext = S_TLR;
			endcase
		end
	endfunction

	// trace chain is the data path only for intest with chain 6 selected
	function isTraceChain;
		input [`TRC_IR_W-1:0] instr;
		input [`TRC_SEL_W-1:0] sel;
		begin
			isTraceChain = (instr == `TRC_IR_INTEST) &&
				(sel == `TRC_CHAIN_NUM);
		end
	endfunction

	// debug pins through the three-stage synchroniser
	assign pinsRaw = {trstN, tdi, tms, tck};

	pin_sync #(
		.WIDTH(`TRC_SYNC_W)
	) u_pin_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(pinsRaw),
		.dout(pins)
	);

	// tck edges seen on the filtered copy
	always @(posedge mclk) begin
		if (!rst_n) begin
			tckPrev <= 1'b0;
		end else begin
			tckPrev <= pins[`TRC_SYNC_TCK];
		end
	end

	assign tckRise = pins[`TRC_SYNC_TCK] & ~tckPrev;
	assign tckFall = ~pins[`TRC_SYNC_TCK] & tckPrev;
	assign tmsIn = pins[`TRC_SYNC_TMS];
	assign tdiIn = pins[`TRC_SYNC_TDI];
	assign tapReset = !rst_n || !pins[`TRC_SYNC_TRST];
	assign next_tapState = tapNext(tapState, tmsIn);
	assign traceChainActive = isTraceChain(ir, chainSel);

	// tap state walks on each tck rising edge
	always @(posedge mclk) begin
		if (tapReset) begin
			tapState <= S_TLR;
		end else if (tckRise) begin
			tapState <= next_tapState;
		end
	end

	// instruction register: capture, shift, update
	always @(posedge mclk) begin
		if (tapReset) begin
			irShift <= `TRC_IR_BYPASS;
			ir <= `TRC_IR_BYPASS;
		end else if (tckRise) begin
			case (tapState)
				S_TLR: begin
					ir <= `TRC_IR_BYPASS;
				end
				S_CAPIR: begin
					irShift <= `TRC_IR_CAPTURE;
				end
				S_SHIR: begin
					irShift <= {tdiIn, irShift[`TRC_IR_W-1:1]};
				end
				default: begin
					if (next_tapState == S_UPIR) begin
						ir <= irShift;
					end
				end
			endcase
		end
	end

	// chain number register, reached by the scan-select instruction
	always @(posedge mclk) begin
		if (tapReset) begin
			selShift <= `TRC_SEL_RESET;
			chainSel <= `TRC_SEL_RESET;
		end else if (tckRise && ir == `TRC_IR_SCAN_N) begin
			case (tapState)
				S_CAPDR: begin
					selShift <= chainSel;
				end
				S_SHDR: begin
					selShift <= {tdiIn, selShift[`TRC_SEL_W-1:1]};
				end
				default: begin
					if (next_tapState == S_UPDR) begin
						chainSel <= selShift;
					end
				end
			endcase
		end
	end

	// 40-bit trace chain: data low, address, rw on top
	always @(posedge mclk) begin
		if (tapReset) begin
			chain <= {`TRC_CHAIN_W{1'b0}};
		end else if (tckRise && isTraceChain(ir, chainSel)) begin
			case (tapState)
				S_CAPDR: begin
					// last read result into the data field
					chain[`TRC_DATA_MSB:`TRC_DATA_LSB] <= readHold;
				end
				S_SHDR: begin
					chain <= {tdiIn, chain[`TRC_CHAIN_W-1:1]};
				end
				default: begin
					chain <= chain;
				end
			endcase
		end
	end

	// bypass bit for every other data path
	always @(posedge mclk) begin
		if (tapReset) begin
			bypassBit <= 1'b0;
		end else if (tckRise) begin
			if (tapState == S_CAPDR) begin
				bypassBit <= 1'b0;
			end else if (tapState == S_SHDR) begin
				bypassBit <= tdiIn;
			end
		end
	end

	// register access issued only on the edge entering update-dr
	always @(posedge mclk) begin
		if (tapReset) begin
			regAddr <= {`TRC_ADDR_W{1'b0}};
			regWrData <= {`TRC_DATA_W{1'b0}};
			regWrite <= 1'b0;
			regRead <= 1'b0;
		end else begin
			regWrite <= 1'b0;
			regRead <= 1'b0;
			if (tckRise && next_tapState == S_UPDR &&
				isTraceChain(ir, chainSel)) begin
				regAddr <= chain[`TRC_ADDR_MSB:`TRC_ADDR_LSB];
				if (chain[`TRC_RW_BIT] == `TRC_RW_WRITE) begin
					regWrData <= chain[`TRC_DATA_MSB:`TRC_DATA_LSB];
					regWrite <= 1'b1;
				end else begin
					regRead <= 1'b1;
				end
			end
		end
	end

	// hold read data, sampled the cycle after the read strobe
	always @(posedge mclk) begin
		if (tapReset) begin
			readPending <= 1'b0;
			readHold <= {`TRC_DATA_W{1'b0}};
		end else begin
			readPending <= regRead;
			if (readPending) begin
				readHold <= regRdData;
			end
		end
	end

	// serial output source for the active path
	always @* begin
		tdoBit = bypassBit;
		if (tapState == S_SHIR) begin
			tdoBit = irShift[0];
		end else if (ir == `TRC_IR_SCAN_N) begin
			tdoBit = selShift[0];
		end else if (isTraceChain(ir, chainSel)) begin
			tdoBit = chain[0];
		end
	end

	// tdo changes on tck falling edge, driven only while shifting
	always @(posedge mclk) begin
		if (tapReset) begin
			tdo <= 1'b0;
			tdoOe <= 1'b0;
		end else if (tckFall) begin
			tdo <= tdoBit;
			tdoOe <= (tapState == S_SHDR) || (tapState == S_SHIR);
		end
	end

endmodule // trace_register_scan_access

`default_nettype wire

// ==== trace_scan_regs.vh ====
// constants for the trace register scan access block
// assumes a single mclk domain; the debug port pins arrive unsynchronised
`ifndef TRACE_SCAN_REGS_VH
`define TRACE_SCAN_REGS_VH

// scan chain layout, shifted least significant bit first
`define TRC_DATA_W 32
`define TRC_ADDR_W 7
`define TRC_CHAIN_W 40
`define TRC_DATA_LSB 0
`define TRC_DATA_MSB 31
`define TRC_ADDR_LSB 32
`define TRC_ADDR_MSB 38
`define TRC_RW_BIT 39
`define TRC_RW_WRITE 1'h1

// chain selection through the core tap
`define TRC_CHAIN_NUM 4'h6
`define TRC_SEL_W 4
`define TRC_SEL_RESET 4'h0

// instruction register
`define TRC_IR_W 4
`define TRC_IR_CAPTURE 4'h1
`define TRC_IR_SCAN_N 4'h2
`define TRC_IR_INTEST 4'hC
`define TRC_IR_BYPASS 4'hF

// synchroniser word: trst, tdi, tms, tck
`define TRC_SYNC_W 4
`define TRC_SYNC_TCK 0
`define TRC_SYNC_TMS 1
`define TRC_SYNC_TDI 2
`define TRC_SYNC_TRST 3

`endif

// ==== pin_sync.v ====
// three-stage synchroniser for the debug port pins
// assumes the pins are asynchronous to mclk; output moves when stages agree
`default_nettype none

module pin_sync #(
	parameter WIDTH = 4
) (
	input wire mclk,
	input wire rst_n,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;
	integer i;

	// stage chain; stage1 feeds only stage2
	always @(posedge mclk) begin
		if (!rst_n) begin
			stage1 <= {WIDTH{1'b0}};
			stage2 <= {WIDTH{1'b0}};
			stage3 <= {WIDTH{1'b0}};
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// accept a bit only once stage2 and stage3 agree
	always @(posedge mclk) begin
		if (!rst_n) begin
			dout <= {WIDTH{1'b0}};
		end else begin
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (stage2[i] == stage3[i]) begin
					dout[i] <= stage3[i];
				end
			end
		end
	end

endmodule // pin_sync

`default_nettype wire

// ==== trace_scan_access_monitor.sv ====
// port checker for the trace register scan access block
// assumes one mclk domain and synchronous active-low rst_n
`include "trace_scan_regs.vh"
`default_nettype none
module trace_scan_access_monitor (
	input wire mclk,
	input wire rst_n,
	input wire tck,
	input wire tms,
	input wire tdo,
	input wire tdoOe,
	input wire [`TRC_ADDR_W-1:0] regAddr,
	input wire [`TRC_DATA_W-1:0] regWrData,
	input wire regWrite,
	input wire regRead,
	input wire traceChainActive
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// quiet outputs while reset holds
	resetQuiet_a: assert property (disable iff (1'b0)
		!rst_n |=> !regWrite && !regRead && !tdoOe)
		else $error("busy in reset");
	// accesses only from the selected chain, on update entry
	chainOnly_a: assert property (
		(regWrite || regRead) |-> traceChainActive)
		else $error("access off chain");
	onUpdate_a: assert property ((regWrite || regRead) |-> tck && tms)
		else $error("access outside update");
	wrPulse_a: assert property (regWrite |=> !regWrite && !regRead)
		else $error("write pulse too long");
	readPure_a: assert property (
		regRead |-> !regWrite && $stable(regWrData))
		else $error("read disturbed data");
	wrHold_a: assert property (!regWrite |-> $stable(regWrData))
		else $error("write data moved");
	addrHold_a: assert property (
		!(regWrite || regRead) |-> $stable(regAddr))
		else $error("address moved");
	tdoFall_a: assert property ($changed(tdo) |-> !tck)
		else $error("tdo moved with tck high");
	// output enable only moves while tck is low
	oeFall_a: assert property ($changed(tdoOe) |-> !tck)
		else $error("enable moved with tck high");
	// main scenarios reached
	wrSeen_c: cover property (regWrite);
	rdSeen_c: cover property (regRead);
	shiftSeen_c: cover property (tdoOe && traceChainActive);
endmodule // trace_scan_access_monitor
bind trace_register_scan_access trace_scan_access_monitor mon_u (
	.mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdo(tdo),
	.tdoOe(tdoOe), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead),
	.traceChainActive(traceChainActive));
`default_nettype wire

// ==== debug_probe_model.sv ====
// debug probe model driving the test port pins
// assumes tck idles low between scans; tdo is read before each rise
`default_nettype none
module debug_probe_model (
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 100ps;
	logic q;
	// pins start idle
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 125 ns tck period, pins held across the rise
	task automatic step(input logic m, input logic d, output logic s);
		tms = m;
		tdi = d;
		#62.5 s = tdo;
		tck = 1'b1;
		#62.5 tck = 1'b0;
	endtask
	// five high tms then idle
	task automatic reset_tap();
		repeat (5) step(1'b1, tdi, q);
		step(1'b0, tdi, q);
	endtask
	// scan from idle through update; released tdi flips
	task automatic scan(input logic ir, input logic [39:0] v,
		input int n, output logic [39:0] o);
		int i;
		o = '0;
		step(1'b1, tdi, q);
		if (ir) step(1'b1, tdi, q);
		step(1'b0, tdi, q);
		step(1'b0, tdi, q);
		for (i = 0; i < n; i++) begin
			step(i == n - 1, v[i], o[i]);
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
endmodule // debug_probe_model
`default_nettype wire

// ==== trace_register_scan_access_tb.sv ====
// self-checking bench for the trace register scan access block
// assumes debug_probe_model drives the pins; bench plays the macrocell
`include "trace_scan_regs.vh"
`default_nettype none
module trace_register_scan_access_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic trstN = 1'b0;
	logic [`TRC_DATA_W-1:0] regRdData = '0;
	wire tck, tms, tdi, tdo, tdoOe, regWrite, regRead, traceChainActive;
	wire [`TRC_ADDR_W-1:0] regAddr;
	wire [`TRC_DATA_W-1:0] regWrData;
	int n_fail = 0;
	int comparisons = 0;
	int nWr = 0;
	int nRd = 0;
	int nOe = 0;
	logic [39:0] o;
	trace_register_scan_access dut_u (.mclk(mclk), .rst_n(rst_n),
		.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo),
		.tdoOe(tdoOe), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.traceChainActive(traceChainActive));
	debug_probe_model probe_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	always #5 mclk = ~mclk;
	function automatic logic [31:0] rdVal(input logic [6:0] a);
		return {a, 25'h15A5A5A};
	endfunction
	// macrocell: data follows address, accesses counted
	always @(posedge mclk) begin
		#1 regRdData = rdVal(regAddr);
		nWr += regWrite;
		nRd += regRead;
	end
	// one drive window per shift phase
	always @(posedge tdoOe) nOe++;
	task automatic check(input string nm, input logic [39:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic t_idle();
		probe_u.scan(1'b0, 40'h80_1234_5678, 40, o);
		check("active", traceChainActive, 1'b0);
		check("bypass", o, 40'h00_2468_ACF0);
		check("access", nWr + nRd, 0);
		check("oewin", nOe, 1);
		check("oeidle", tdoOe, 1'b0);
		$display("idle done");
	endtask
	task automatic t_select();
		probe_u.scan(1'b1, `TRC_IR_SCAN_N, 4, o);
		check("ircap", o[3:0], `TRC_IR_CAPTURE);
		probe_u.scan(1'b0, `TRC_CHAIN_NUM, 4, o);
		check("oldsel", o[3:0], `TRC_SEL_RESET);
		probe_u.scan(1'b1, `TRC_IR_INTEST, 4, o);
		check("active", traceChainActive, 1'b1);
		$display("select done");
	endtask
	task automatic t_write();
		probe_u.scan(1'b0, {`TRC_RW_WRITE, 7'h7F, 32'hC3A5_0F96}, 40, o);
		check("writes", nWr, 1);
		check("reads", nRd, 0);
		check("addr", regAddr, 7'h7F);
		check("wdata", regWrData, 32'hC3A5_0F96);
		$display("write done");
	endtask
	task automatic t_read();
		probe_u.scan(1'b0, {1'b0, 7'h2A, 32'hFFFF_FFFF}, 40, o);
		check("reads", nRd, 1);
		check("writes", nWr, 1);
		check("addr", regAddr, 7'h2A);
		check("wdata", regWrData, 32'hC3A5_0F96);
		probe_u.scan(1'b0, 40'h0, 40, o);
		check("rdback", o, {8'h2A, rdVal(7'h2A)});
		check("addr0", regAddr, 7'h00);
		check("writes", nWr, 1);
		check("oewin", nOe, 7);
		$display("read done");
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		#1 rst_n = 1'b1;
		trstN = 1'b1;
		repeat (8) @(posedge mclk);
		probe_u.reset_tap();
		t_idle();
		t_select();
		t_write();
		t_read();
		wrap_up();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		wrap_up();
	end
endmodule // trace_register_scan_access_tb
`default_nettype wire
